// File: core/cbsc_pkg.sv
package cbsc_pkg;

  // ====================================================================
  // register map (byte addresses)
  localparam logic [7:0] SOCK_CTRL_OFS = 8'h10;
  localparam logic [7:0] SOCK_STAT_OFS = 8'h14;

  // ====================================================================
  // socket control field positions
  localparam int ACTIVITY_BIT = 11;
  localparam int STD_MODEL_BIT = 10;
  localparam int VIDEO_EN_BIT = 9;
  localparam int POLICY_BIT = 7;
  localparam int VCC_LSB = 4;
  localparam int VPP_LSB = 0;
  localparam int FIELD_W = 3;
  localparam logic [31:0] SOCK_CTRL_RESET = 32'h0000_0400;

  // status register field positions
  localparam int STAT_PWR_EN_BIT = 8;
  localparam int STAT_CLK_STOP_BIT = 7;
  localparam int STAT_VCC_LSB = 4;
  localparam int STAT_VPP_LSB = 0;

  // ====================================================================
  // supply request codes
  localparam logic [2:0] SUP_OFF = 3'h0;
  localparam logic [2:0] VPP_12V = 3'h1;
  localparam logic [2:0] SUP_5V = 3'h2;
  localparam logic [2:0] SUP_3V3 = 3'h3;
  localparam logic [2:0] SUP_XV = 3'h4;
  localparam logic [2:0] SUP_YV = 3'h5;

  // ====================================================================
  // clock-run idle qualification
  localparam int IDLE_CLOCKS = 8;
  localparam int IDLE_CNT_W = 4;

  // ====================================================================
  // power control lock machine
  typedef enum logic [1:0] {
    CBSC_PWR_ENABLED = 2'b01,
    CBSC_PWR_LOCKED = 2'b10
  } cbsc_pwr_state_t;

  typedef struct packed {
    logic [IDLE_CNT_W-1:0] cnt;
    logic met;
  } cbsc_idle_state_t;

  typedef struct packed {
    logic [2:0] vcc_req;
    logic [2:0] vpp_req;
    logic policy;
    logic video_en;
    logic [2:0] vcc_applied;
    logic [2:0] vpp_applied;
    cbsc_pwr_state_t pwr;
    logic clk_stop;
    logic [31:0] rdata;
  } cbsc_ctrl_state_t;

endpackage

// File: core/cbsc_idle_timer.sv
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// idle qualifier: flags after N consecutive idle card-interface clocks
module cbsc_idle_timer #(
  parameter int IDLE_CLOCKS = cbsc_pkg::IDLE_CLOCKS
) (
  input wire logic clk, // bus clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic card_if_idle, // card interface idle this clock
  output logic idle_met // idle for the full window
);

  cbsc_pkg::cbsc_idle_state_t s_q;
  cbsc_pkg::cbsc_idle_state_t s_d;

  localparam logic [cbsc_pkg::IDLE_CNT_W-1:0] LAST =
    cbsc_pkg::IDLE_CNT_W'(IDLE_CLOCKS - 1);

  // count up while idle; any busy clock restarts the window
  always_comb
  begin
    s_d = s_q;
    if (!card_if_idle)
    begin
      s_d.cnt = '0;
      s_d.met = 1'b0;
    end
    else
    begin
      // RULE5 eight idle clocks
      if (s_q.cnt != LAST)
        s_d.cnt = s_q.cnt + 1'b1;
      s_d.met = (s_q.cnt == LAST);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end

  assign idle_met = s_q.met;

  // ====================================================================
  // checks
  idle_window_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    (ce && card_if_idle) [*8] |=> idle_met)
    else $error("idle not flagged after eight idle clocks");
  busy_clears_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    (ce && !card_if_idle) |=> !idle_met)
    else $error("idle flag survived a busy clock");

endmodule

`default_nettype wire

// File: core/cbsc_socket_ctrl.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE1 - bits 31 to 12 of socket control read as zero and writes to them are dropped.
// RULE2 - the video activity bit reads 1 when either socket's video enable is set, else 0.
// RULE3 - the video register model bit reads as a constant 1 and cannot be written.
// RULE4 - the video enable bit is read/write, resets to 0 and drives this socket's video path.
// RULE5 - with the halt policy clear the card clock stops only after eight idle clocks and a host stop request.
// RULE6 - with the halt policy set the card clock stops after eight idle clocks, whatever the host requests.
// RULE7 - card supply codes are 000 off, 010 5 V, 011 3.3 V, 100 X.X V, 101 Y.Y V, the rest reserved.
// RULE8 - programming supply codes are 000 off, 001 12 V, 010 5 V, 011 3.3 V, 100 X.X V, 101 Y.Y V, 11x reserved.
// RULE9 - bit 3 and bit 8 of socket control always read as zero.
// RULE10 - a supply request is applied only when the card accepts that voltage (programming 12 V only when ALLOW_VPP_12V is set), otherwise the supply stays off.
// RULE11 - a forced voltage indication locks socket power control until a card reinterrogation unlocks it.
// RULE12 - after reset socket control reads 0x00000400.
module cbsc_socket_ctrl #(
  parameter int ADDR_W = 8,
  parameter int IDLE_CLOCKS = cbsc_pkg::IDLE_CLOCKS,
  parameter bit ALLOW_VPP_12V = 1'b1
) (
  input wire logic clk, // bus clock, 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic [ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic other_video_enable, // other socket's video enable
  input wire logic card_if_idle, // card interface idle
  input wire logic host_clkrun_stop, // host bus side asks to stop
  input wire logic card_vs_5v, // card accepts 5 V
  input wire logic card_vs_3v3, // card accepts 3.3 V
  input wire logic card_vs_xv, // card accepts X.X V
  input wire logic card_vs_yv, // card accepts Y.Y V
  input wire logic force_vs_indication, // pulse: software forced a voltage flag
  input wire logic card_reinterrogate, // pulse: reinterrogation requested
  output logic video_port_enable, // zoomed video path on
  output logic card_clk_stop, // request card clock stop
  output logic [2:0] card_supply_apply, // supply code applied to socket
  output logic [2:0] program_supply_apply, // programming supply applied
  output logic power_ctrl_enabled // power control not locked
);

  cbsc_pkg::cbsc_ctrl_state_t s_q;
  cbsc_pkg::cbsc_ctrl_state_t s_d;
  logic idle_met;
  logic ctrl_sel;
  logic stat_sel;
  logic vcc_ok;
  logic vpp_ok;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  // ====================================================================
  // idle qualification
  cbsc_idle_timer #(
    .IDLE_CLOCKS(IDLE_CLOCKS)
  ) u_idle (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .card_if_idle(card_if_idle),
    .idle_met(idle_met)
  );

  // ====================================================================
  // address decode
  // only the two mapped offsets answer; every other address reads zero and drops writes
  assign ctrl_sel = (reg_addr == ADDR_W'(cbsc_pkg::SOCK_CTRL_OFS));
  assign stat_sel = (reg_addr == ADDR_W'(cbsc_pkg::SOCK_STAT_OFS));

  // ====================================================================
  // voltage acceptance against the card's capabilities
  // power off is always accepted, so removing power never waits on the card
  always_comb
  begin
    // RULE7 card supply decode
    case (s_q.vcc_req)
      cbsc_pkg::SUP_OFF: vcc_ok = 1'b1;
      cbsc_pkg::SUP_5V: vcc_ok = card_vs_5v;
      cbsc_pkg::SUP_3V3: vcc_ok = card_vs_3v3;
      cbsc_pkg::SUP_XV: vcc_ok = card_vs_xv;
      cbsc_pkg::SUP_YV: vcc_ok = card_vs_yv;
      default: vcc_ok = 1'b0; // reserved codes never reach the switch
    endcase
    // RULE8 programming supply decode, 010 taken as 5 V
    case (s_q.vpp_req)
      cbsc_pkg::SUP_OFF: vpp_ok = 1'b1;
      cbsc_pkg::VPP_12V: vpp_ok = ALLOW_VPP_12V;
      cbsc_pkg::SUP_5V: vpp_ok = card_vs_5v;
      cbsc_pkg::SUP_3V3: vpp_ok = card_vs_3v3;
      cbsc_pkg::SUP_XV: vpp_ok = card_vs_xv;
      cbsc_pkg::SUP_YV: vpp_ok = card_vs_yv;
      default: vpp_ok = 1'b0;
    endcase
  end

  // ====================================================================
  // read words
  always_comb
  begin
    // RULE1 upper bits zero
    ctrl_word = '0;
    // RULE2 activity from both sockets
    ctrl_word[cbsc_pkg::ACTIVITY_BIT] = s_q.video_en | other_video_enable;
    // RULE3 model bit hardwired
    ctrl_word[cbsc_pkg::STD_MODEL_BIT] = 1'b1;
    ctrl_word[cbsc_pkg::VIDEO_EN_BIT] = s_q.video_en;
    ctrl_word[cbsc_pkg::POLICY_BIT] = s_q.policy;
    ctrl_word[cbsc_pkg::VCC_LSB +: cbsc_pkg::FIELD_W] = s_q.vcc_req;
    ctrl_word[cbsc_pkg::VPP_LSB +: cbsc_pkg::FIELD_W] = s_q.vpp_req;
    // RULE9 bits 8 and 3 stay at zero from the clear above
    stat_word = '0;
    stat_word[cbsc_pkg::STAT_PWR_EN_BIT] = (s_q.pwr == cbsc_pkg::CBSC_PWR_ENABLED);
    stat_word[cbsc_pkg::STAT_CLK_STOP_BIT] = s_q.clk_stop;
    stat_word[cbsc_pkg::STAT_VCC_LSB +: cbsc_pkg::FIELD_W] = s_q.vcc_applied;
    stat_word[cbsc_pkg::STAT_VPP_LSB +: cbsc_pkg::FIELD_W] = s_q.vpp_applied;
  end

  // ====================================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    // read data stand for one cycle only; unmapped reads give zero
    s_d.rdata = '0;
    if (reg_rd)
    begin
      if (ctrl_sel)
        s_d.rdata = ctrl_word;
      else if (stat_sel)
        s_d.rdata = stat_word;
    end

    // software writes: only the writable fields are kept
    if (reg_wr && ctrl_sel)
    begin
      // RULE4 video enable stored
      s_d.video_en = reg_wdata[cbsc_pkg::VIDEO_EN_BIT];
      s_d.policy = reg_wdata[cbsc_pkg::POLICY_BIT];
      s_d.vcc_req = reg_wdata[cbsc_pkg::VCC_LSB +: cbsc_pkg::FIELD_W];
      s_d.vpp_req = reg_wdata[cbsc_pkg::VPP_LSB +: cbsc_pkg::FIELD_W];
    end

    // RULE11 lock and unlock power control
    case (s_q.pwr)
      cbsc_pkg::CBSC_PWR_ENABLED:
      begin
        if (force_vs_indication)
          s_d.pwr = cbsc_pkg::CBSC_PWR_LOCKED;
      end
      cbsc_pkg::CBSC_PWR_LOCKED:
      begin
        // a force in the same cycle keeps the lock: the newer event wins
        if (card_reinterrogate && !force_vs_indication)
          s_d.pwr = cbsc_pkg::CBSC_PWR_ENABLED;
      end
      default: s_d.pwr = cbsc_pkg::CBSC_PWR_LOCKED; // unknown code is unsafe
    endcase

    // RULE10 apply only accepted voltages
    // while locked the switch holds its last setting rather than dropping the card
    if (s_q.pwr == cbsc_pkg::CBSC_PWR_ENABLED)
    begin
      s_d.vcc_applied = vcc_ok ? s_q.vcc_req : cbsc_pkg::SUP_OFF;
      s_d.vpp_applied = vpp_ok ? s_q.vpp_req : cbsc_pkg::SUP_OFF;
    end

    // RULE5 host request needed with policy clear
    // RULE6 policy set ignores host request
    s_d.clk_stop = idle_met && (s_q.policy || host_clkrun_stop);
  end

  // ====================================================================
  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // RULE12 reset value: all state zero except power control enabled, model bit is the constant 1
      s_q <= '0;
      s_q.pwr <= cbsc_pkg::CBSC_PWR_ENABLED;
    end
    else if (ce)
      s_q <= s_d;
  end

  // ====================================================================
  // outputs
  assign reg_rdata = s_q.rdata;
  assign video_port_enable = s_q.video_en;
  assign card_clk_stop = s_q.clk_stop;
  assign card_supply_apply = s_q.vcc_applied;
  assign program_supply_apply = s_q.vpp_applied;
  assign power_ctrl_enabled = (s_q.pwr == cbsc_pkg::CBSC_PWR_ENABLED);

  // ====================================================================
  // checks
  // all checks run on the bus clock and sleep through reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // a control read that the block really takes, clock enable included
  logic rd_ctrl;
  assign rd_ctrl = ce && reg_rd && ctrl_sel;

  reserved_high_a: assert property (rd_ctrl |=> reg_rdata[31:12] == 20'h0_0000) // RULE1
    else $error("reserved upper bits read nonzero");
  activity_bit_a: assert property ( // RULE2
    rd_ctrl |=> reg_rdata[cbsc_pkg::ACTIVITY_BIT] == ($past(s_q.video_en) | $past(other_video_enable)))
    else $error("video activity bit wrong");
  model_bit_a: assert property (rd_ctrl |=> reg_rdata[cbsc_pkg::STD_MODEL_BIT]) // RULE3
    else $error("model bit not one");
  video_write_a: assert property ( // RULE4
    (ce && reg_wr && ctrl_sel) |=> video_port_enable == $past(reg_wdata[cbsc_pkg::VIDEO_EN_BIT]))
    else $error("video enable did not follow write");
  host_gate_a: assert property ( // RULE5
    (ce && !s_q.policy && !host_clkrun_stop) |=> !card_clk_stop)
    else $error("clock stopped without host request");
  policy_stop_a: assert property ((ce && idle_met && s_q.policy) |=> card_clk_stop) // RULE6
    else $error("clock not stopped under halt policy");
  vpp_reserved_a: assert property ( // RULE8
    (ce && power_ctrl_enabled && s_q.vpp_req[2:1] == 2'b11) |=> program_supply_apply == cbsc_pkg::SUP_OFF)
    else $error("reserved programming code applied");
  reserved_mid_a: assert property ( // RULE9
    rd_ctrl |=> (reg_rdata[8] == 1'b0) && (reg_rdata[3] == 1'b0))
    else $error("reserved bits 8 or 3 nonzero");
  unsupported_off_a: assert property ( // RULE10
    (ce && power_ctrl_enabled && ((s_q.vcc_req == cbsc_pkg::SUP_5V && !card_vs_5v) ||
      (s_q.vcc_req == cbsc_pkg::SUP_3V3 && !card_vs_3v3) || (s_q.vcc_req == cbsc_pkg::SUP_XV && !card_vs_xv) ||
      (s_q.vcc_req == cbsc_pkg::SUP_YV && !card_vs_yv)))
    |=> card_supply_apply == cbsc_pkg::SUP_OFF)
    else $error("unsupported card voltage applied");
  lock_hold_a: assert property ( // RULE11
    (ce && force_vs_indication) |=> !power_ctrl_enabled ##1 ($stable(card_supply_apply) || power_ctrl_enabled))
    else $error("power control not locked by force");

  // ====================================================================
  // register port checks
  // a strobe that misses both registers, or no strobe at all, leaves the data at zero
  rdata_idle_a: assert property ( // RULE1
    (ce && !(reg_rd && (ctrl_sel || stat_sel))) |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  status_lock_a: assert property ( // RULE11
    (ce && reg_rd && stat_sel) |=> reg_rdata[cbsc_pkg::STAT_PWR_EN_BIT] == $past(power_ctrl_enabled))
    else $error("status shows wrong power control state");
  write_drop_a: assert property ( // RULE4
    (ce && reg_wr && !ctrl_sel) |=> $stable(video_port_enable))
    else $error("write to another address changed video enable");
  // a frozen block must not move any output, or software would see half an update
  freeze_hold_a: assert property ( // RULE4
    !ce |=> $stable(video_port_enable) && $stable(reg_rdata) && $stable(card_supply_apply))
    else $error("outputs moved while clock enable low");

  // ====================================================================
  // supply checks
  vcc_reserved_a: assert property ( // RULE7
    (ce && power_ctrl_enabled && (s_q.vcc_req == 3'h1 || s_q.vcc_req[2:1] == 2'b11))
    |=> card_supply_apply == cbsc_pkg::SUP_OFF)
    else $error("reserved card supply code applied");
  vpp_12v_a: assert property ( // RULE8
    (ce && power_ctrl_enabled && s_q.vpp_req == cbsc_pkg::VPP_12V)
    |=> program_supply_apply == (ALLOW_VPP_12V ? cbsc_pkg::VPP_12V : cbsc_pkg::SUP_OFF))
    else $error("programming supply 12 V handled wrongly");
  accepted_apply_a: assert property ( // RULE10
    (ce && power_ctrl_enabled && s_q.vcc_req == cbsc_pkg::SUP_3V3 && card_vs_3v3)
    |=> card_supply_apply == cbsc_pkg::SUP_3V3)
    else $error("accepted card voltage not applied");

  // ====================================================================
  // lock checks
  unlock_a: assert property ( // RULE11
    (ce && !power_ctrl_enabled && card_reinterrogate && !force_vs_indication) |=> power_ctrl_enabled)
    else $error("reinterrogation did not unlock power control");
  force_wins_a: assert property ( // RULE11
    (ce && force_vs_indication && card_reinterrogate) |=> !power_ctrl_enabled)
    else $error("power control unlocked despite a force");
  // while locked the switch keeps its setting, so a lock never drops a running card
  locked_frozen_a: assert property ( // RULE11
    (ce && !power_ctrl_enabled && !card_reinterrogate)
    |=> $stable(card_supply_apply) && $stable(program_supply_apply))
    else $error("supplies changed while power control locked");

  // ====================================================================
  // clock-run checks
  stop_needs_idle_a: assert property ((ce && !idle_met) |=> !card_clk_stop) // RULE5
    else $error("clock stopped before the idle window");
  host_stop_a: assert property ((ce && idle_met && host_clkrun_stop) |=> card_clk_stop) // RULE5
    else $error("clock not stopped on host request");

  // ====================================================================
  // covers
  cover_stop_host_c: cover property (ce && idle_met && !s_q.policy && host_clkrun_stop ##1 card_clk_stop);
  cover_unlock_c: cover property (!power_ctrl_enabled ##1 power_ctrl_enabled);
  cover_apply_3v3_c: cover property (card_supply_apply == cbsc_pkg::SUP_3V3);
  cover_video_c: cover property (rd_ctrl ##1 reg_rdata[cbsc_pkg::ACTIVITY_BIT]);
  cover_freeze_c: cover property (!ce ##1 !ce);

endmodule

`default_nettype wire

// File: dv/cbsc_card_model.sv
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// card in the socket: voltage sense flags and interface activity
module cbsc_card_model #(
  parameter logic [3:0] VS_CAPS = 4'h3 // accepted: [0] 5 V, [1] 3.3 V, [2] X.X V, [3] Y.Y V
) (
  input wire logic clk, // bus clock
  input wire logic rst, // async reset, active high
  input wire logic card_busy, // bench asks the card to run a transaction
  output logic card_vs_5v, // card accepts 5 V
  output logic card_vs_3v3, // card accepts 3.3 V
  output logic card_vs_xv, // card accepts X.X V
  output logic card_vs_yv, // card accepts Y.Y V
  output logic card_if_idle // interface idle this clock
);
  // fixed sense pins
  // sense pins are static for a seated card, so they carry no timing
  assign card_vs_5v = VS_CAPS[0];
  assign card_vs_3v3 = VS_CAPS[1];
  assign card_vs_xv = VS_CAPS[2];
  assign card_vs_yv = VS_CAPS[3];

  // activity is registered, like a real card answering a clock late
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      card_if_idle <= 1'b0;
    else
      card_if_idle <= !card_busy;
  end
endmodule

`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// bench top: register port master, card model, scenario tasks
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic other_video_enable = 1'b0;
  logic host_clkrun_stop = 1'b0;
  logic force_vs_indication = 1'b0;
  logic card_reinterrogate = 1'b0;
  logic card_busy = 1'b1;
  logic vs5, vs33, vsx, vsy, idle;
  logic video_port_enable, card_clk_stop, power_ctrl_enabled;
  logic [2:0] card_supply_apply, program_supply_apply;
  int n_fail = 0;
  int total_checks = 0;

  always #5 clk = !clk;

  cbsc_card_model #(.VS_CAPS(4'h3)) cbsc_card_model_i (.clk(clk), .rst(rst), .card_busy(card_busy),
    .card_vs_5v(vs5), .card_vs_3v3(vs33), .card_vs_xv(vsx), .card_vs_yv(vsy), .card_if_idle(idle));

  cbsc_socket_ctrl cbsc_socket_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .other_video_enable(other_video_enable), .card_if_idle(idle), .host_clkrun_stop(host_clkrun_stop),
    .card_vs_5v(vs5), .card_vs_3v3(vs33), .card_vs_xv(vsx), .card_vs_yv(vsy),
    .force_vs_indication(force_vs_indication), .card_reinterrogate(card_reinterrogate),
    .video_port_enable(video_port_enable), .card_clk_stop(card_clk_stop),
    .card_supply_apply(card_supply_apply), .program_supply_apply(program_supply_apply),
    .power_ctrl_enabled(power_ctrl_enabled));

  // ====================================================================
  // shared helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("read word", exp, reg_rdata);
  endtask

  // expected applied code for a seated card taking 5 V and 3.3 V only
  function automatic logic [2:0] exp_apply(input logic [2:0] c, input bit is_vpp);
    if (c == cbsc_pkg::SUP_5V || c == cbsc_pkg::SUP_3V3)
      return c;
    if (is_vpp && c == cbsc_pkg::VPP_12V)
      return c;
    return cbsc_pkg::SUP_OFF;
  endfunction

  // ====================================================================
  // scenarios
  task automatic t_reset_and_map();
    rd(8'h10, 32'h0000_0400);
    rd(8'h20, 32'h0);
    wr(8'hff, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0400);
  endtask

  task automatic t_fixed_bits();
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0ef7);
    chk("video enable", 32'h1, {31'h0, video_port_enable});
    wr(8'h10, 32'h0000_0000);
    rd(8'h10, 32'h0000_0400);
    chk("video enable", 32'h0, {31'h0, video_port_enable});
  endtask

  task automatic t_activity();
    @(posedge clk);
    other_video_enable <= 1'b1;
    rd(8'h10, 32'h0000_0c00);
    wr(8'h10, 32'h0000_0200);
    rd(8'h10, 32'h0000_0e00);
    @(posedge clk);
    other_video_enable <= 1'b0;
    rd(8'h10, 32'h0000_0e00);
    wr(8'h10, 32'h0000_0000);
    rd(8'h10, 32'h0000_0400);
  endtask

  // a write while the clock enable is low must be dropped
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h10, 32'h0000_0200);
    @(posedge clk);
    ce <= 1'b1;
    chk("video enable frozen", 32'h0, {31'h0, video_port_enable});
    rd(8'h10, 32'h0000_0400);
  endtask

  // every code in both fields, reserved ones included, against the card
  task automatic t_supplies();
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h10, {25'h0, c[2:0], 1'b0, c[2:0]});
      repeat (3) @(posedge clk);
      chk("card supply", {29'h0, exp_apply(c[2:0], 1'b0)}, {29'h0, card_supply_apply});
      chk("program supply", {29'h0, exp_apply(c[2:0], 1'b1)}, {29'h0, program_supply_apply});
      rd(8'h10, {20'h0, 4'h4, 1'b0, c[2:0], 1'b0, c[2:0]});
    end
  endtask

  task automatic t_lock();
    wr(8'h10, 32'h0000_0030);
    repeat (3) @(posedge clk);
    force_vs_indication <= 1'b1;
    @(posedge clk);
    force_vs_indication <= 1'b0;
    wr(8'h10, 32'h0000_0020);
    repeat (3) @(posedge clk);
    chk("power enabled", 32'h0, {31'h0, power_ctrl_enabled});
    chk("card supply", 32'h3, {29'h0, card_supply_apply});
    rd(8'h14, 32'h0000_0030);
    @(posedge clk);
    card_reinterrogate <= 1'b1;
    @(posedge clk);
    card_reinterrogate <= 1'b0;
    repeat (3) @(posedge clk);
    chk("power enabled", 32'h1, {31'h0, power_ctrl_enabled});
    chk("card supply", 32'h2, {29'h0, card_supply_apply});
    rd(8'h14, 32'h0000_0120);
    // force and reinterrogation in one cycle: the force wins
    @(posedge clk);
    force_vs_indication <= 1'b1;
    card_reinterrogate <= 1'b1;
    @(posedge clk);
    force_vs_indication <= 1'b0;
    card_reinterrogate <= 1'b0;
    repeat (2) @(posedge clk);
    chk("power enabled", 32'h0, {31'h0, power_ctrl_enabled});
    card_reinterrogate <= 1'b1;
    @(posedge clk);
    card_reinterrogate <= 1'b0;
    repeat (2) @(posedge clk);
    chk("power enabled", 32'h1, {31'h0, power_ctrl_enabled});
  endtask

  // idle run past the window: no stop after 6 clocks, stop as exp says after 12, none once busy again
  task automatic t_clkrun(input logic pol, input logic host, input logic exp);
    wr(8'h10, {24'h0, pol, 7'h0});
    @(posedge clk);
    host_clkrun_stop <= host;
    card_busy <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("early clock stop", 32'h0, {31'h0, card_clk_stop});
    repeat (6) @(posedge clk);
    #1;
    chk("clock stop", {31'h0, exp}, {31'h0, card_clk_stop});
    @(posedge clk);
    card_busy <= 1'b1;
    host_clkrun_stop <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("clock stop after busy", 32'h0, {31'h0, card_clk_stop});
  endtask

  // ====================================================================
  // verdict and run control
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_and_map();
    t_fixed_bits();
    t_activity();
    t_freeze();
    t_supplies();
    t_lock();
    t_clkrun(1'b0, 1'b0, 1'b0);
    t_clkrun(1'b0, 1'b1, 1'b1);
    t_clkrun(1'b1, 1'b0, 1'b1);
    test_done();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #100us;
    n_fail++;
    test_done();
  end
endmodule

`default_nettype wire
